// >>> core/vout_ctrl_pkg.sv
// Constants shared by the output voltage configuration register and its decoder.
package vout_ctrl_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam int        ADDR_W                 = 8;
   localparam int        DATA_W                 = 8;
   localparam logic [7:0] VOUT_CTRL_ADDR        = 8'h06;
   localparam logic [7:0] VOUT_CTRL_RESET       = 8'hAA;
   localparam logic [7:0] READ_UNMAPPED_VALUE   = 8'h00;

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int        ENABLE_BIT             = 7;
   localparam int        RANGE_MSB              = 6;
   localparam int        RANGE_LSB              = 5;
   localparam int        CODE_MSB               = 4;
   localparam int        CODE_LSB               = 1;
   localparam int        UNUSED_BIT             = 0;

   // ----------------------------------------------------------------------
   // Range encodings and voltages in millivolts
   // ----------------------------------------------------------------------
   localparam logic [1:0] RANGE_TABLE_LOW       = 2'h0;
   localparam logic [1:0] RANGE_LINEAR_LOW      = 2'h1;
   localparam logic [1:0] RANGE_TABLE_HIGH      = 2'h2;
   localparam logic [1:0] RANGE_LINEAR_HIGH     = 2'h3;
   localparam int        MV_W                   = 12;
   localparam logic [11:0] LINEAR_LOW_BASE_MV   = 12'd1300;
   localparam logic [11:0] LINEAR_HIGH_BASE_MV  = 12'd1800;
   localparam logic [11:0] LINEAR_STEP_MV       = 12'd100;
   localparam logic [11:0] RAIL_OFF_MV          = 12'd0;
   localparam logic [11:0] TARGET_RESET_MV      = 12'd1800;

   typedef logic [11:0] mv_table_t [16];

   localparam mv_table_t TABLE_LOW_MV = '{
      12'd1100, 12'd1200, 12'd1250, 12'd1333, 12'd1417, 12'd1500, 12'd1583, 12'd1667,
      12'd1750, 12'd1833, 12'd1917, 12'd2000, 12'd2083, 12'd2167, 12'd2250, 12'd2333};

   localparam mv_table_t TABLE_HIGH_MV = '{
      12'd1500, 12'd1583, 12'd1667, 12'd1750, 12'd1833, 12'd1917, 12'd2000, 12'd2083,
      12'd2167, 12'd2250, 12'd2333, 12'd2417, 12'd2500, 12'd2583, 12'd2667, 12'd2750};

endpackage

// >>> core/vout_target_decode.sv
// Combinational decode of range select and voltage code into a target in millivolts.
`timescale 1ns/1ps
module vout_target_decode
   import vout_ctrl_pkg::*;
(
   input  wire logic [1:0]  output_range_select_i,
   input  wire logic [3:0]  output_voltage_code_i,
   output logic      [11:0] target_mv_o
);

   // ----------------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------------
   // The linear ranges weigh the code bits 800, 400, 200 and 100 mV.
   always_comb begin
      case (output_range_select_i)
         RANGE_TABLE_LOW: begin
            target_mv_o = TABLE_LOW_MV[output_voltage_code_i];
         end
         RANGE_LINEAR_LOW: begin
            target_mv_o = 12'(LINEAR_LOW_BASE_MV + LINEAR_STEP_MV * output_voltage_code_i);
         end
         RANGE_TABLE_HIGH: begin
            target_mv_o = TABLE_HIGH_MV[output_voltage_code_i];
         end
         RANGE_LINEAR_HIGH: begin
            target_mv_o = 12'(LINEAR_HIGH_BASE_MV + LINEAR_STEP_MV * output_voltage_code_i);
         end
         default: begin
            target_mv_o = RAIL_OFF_MV;
         end
      endcase
   end

endmodule

// >>> core/vout_ctrl_reg.sv
// Output voltage control register with read port and regulation target decode.
`timescale 1ns/1ps
// What this block does
// - Register sits at address 0x06 and resets to 1010 1010.
// - Bit 7 enables switching; when cleared the regulated output is pulled low.
// - Range 00 decodes the code through a fixed sixteen-entry lookup, 1.1 to 2.333 V.
// - Range 01 gives 1.30 V plus code times 100 mV.
// - Range 10 maps codes onto 1.5 V through 2.75 V in about 83.3 mV steps.
// - Range 11 gives 1.80 V plus code times 100 mV.
// - Code lives in bits 4:1; linear ranges weigh bits 800, 400, 200, 100 mV.
module vout_ctrl_reg
   import vout_ctrl_pkg::*;
(
   input  wire logic              ref_clk_i,
   input  wire logic              rst_n_i,
   input  wire logic [ADDR_W-1:0] reg_addr_i,
   input  wire logic              reg_wr_en_i,
   input  wire logic [DATA_W-1:0] reg_wr_data_i,
   input  wire logic              reg_rd_en_i,
   output logic      [DATA_W-1:0] reg_rd_data_o,
   output logic                   switcher_output_enable_o,
   output logic      [1:0]        output_range_select_o,
   output logic      [3:0]        output_voltage_code_o,
   output logic                   switching_node_output_o,
   output logic      [MV_W-1:0]   regulated_rail_voltage_o
);

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   logic [DATA_W-1:0] vout_ctrl_reg;
   logic [DATA_W-1:0] vout_ctrl_next;
   logic [DATA_W-1:0] rd_data_reg;
   logic [MV_W-1:0]   rail_mv_reg;
   logic              switching_reg;
   logic [MV_W-1:0]   decoded_mv;
   logic              hit_wr;
   logic              hit_rd;

   assign hit_wr = reg_wr_en_i && (reg_addr_i == VOUT_CTRL_ADDR);
   assign hit_rd = reg_rd_en_i && (reg_addr_i == VOUT_CTRL_ADDR);

   // Bit 0 has no storage, so a written 1 is dropped here.
   always_comb begin
      vout_ctrl_next             = vout_ctrl_reg;
      if (hit_wr) begin
         vout_ctrl_next          = reg_wr_data_i;
      end
      vout_ctrl_next[UNUSED_BIT] = 1'b0;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         vout_ctrl_reg <= VOUT_CTRL_RESET;
      end else begin
         vout_ctrl_reg <= vout_ctrl_next;
      end
   end

   // ----------------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------------
   // Read data appears one cycle after the request and holds until the next read.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_data_reg <= READ_UNMAPPED_VALUE;
      end else if (hit_rd) begin
         rd_data_reg <= vout_ctrl_reg;
      end else if (reg_rd_en_i) begin
         rd_data_reg <= READ_UNMAPPED_VALUE;
      end
   end

   assign reg_rd_data_o = rd_data_reg;

   // ----------------------------------------------------------------------
   // Field outputs and regulation target
   // ----------------------------------------------------------------------
   assign switcher_output_enable_o = vout_ctrl_reg[ENABLE_BIT];
   assign output_range_select_o    = vout_ctrl_reg[RANGE_MSB:RANGE_LSB];
   assign output_voltage_code_o    = vout_ctrl_reg[CODE_MSB:CODE_LSB];

   vout_target_decode u_decode (
      .output_range_select_i (vout_ctrl_reg[RANGE_MSB:RANGE_LSB]),
      .output_voltage_code_i (vout_ctrl_reg[CODE_MSB:CODE_LSB]),
      .target_mv_o           (decoded_mv)
   );

   // A disabled switcher pulls the rail low, so its target reads as zero.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rail_mv_reg   <= TARGET_RESET_MV;
         switching_reg <= 1'b1;
      end else begin
         switching_reg <= vout_ctrl_reg[ENABLE_BIT];
         rail_mv_reg   <= vout_ctrl_reg[ENABLE_BIT] ? decoded_mv : RAIL_OFF_MV;
      end
   end

   assign switching_node_output_o  = switching_reg;
   assign regulated_rail_voltage_o = rail_mv_reg;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   sequence s_write_hit;
      reg_wr_en_i && (reg_addr_i == VOUT_CTRL_ADDR);
   endsequence

   sequence s_read_hit;
      reg_rd_en_i && (reg_addr_i == VOUT_CTRL_ADDR);
   endsequence

   sequence s_read_other;
      reg_rd_en_i && (reg_addr_i != VOUT_CTRL_ADDR);
   endsequence

   sequence s_enabled_range(logic [1:0] rng);
      vout_ctrl_reg[ENABLE_BIT] && (vout_ctrl_reg[RANGE_MSB:RANGE_LSB] == rng);
   endsequence

   sequence s_enabled_code(logic [1:0] rng, logic [3:0] code);
      s_enabled_range(rng) ##0 (vout_ctrl_reg[CODE_MSB:CODE_LSB] == code);
   endsequence

   a_reset_value_load: assert property (
      @(posedge ref_clk_i) (!$past(rst_n_i) && rst_n_i) |-> (vout_ctrl_reg == 8'hAA))
      else $error("register did not hold its reset pattern after reset release");

   a_write_takes_effect: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_write_hit |=> (vout_ctrl_reg[7:1] == $past(reg_wr_data_i[7:1])))
      else $error("write to the control register did not update its fields");

   a_other_addr_ignored: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (reg_addr_i != 8'h06) |=> $stable(vout_ctrl_reg))
      else $error("access to another address changed the control register");

   a_readback_value: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (s_read_hit ##0 !reg_wr_en_i) |=> (reg_rd_data_o == $past(vout_ctrl_reg)))
      else $error("read data does not match the stored register");

   a_unused_bit_zero: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !vout_ctrl_reg[0] && !reg_rd_data_o[0])
      else $error("unused bit 0 is not zero");

   a_disable_pulls_low: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !vout_ctrl_reg[7] [*2] |-> (regulated_rail_voltage_o == 12'd0 && !switching_node_output_o))
      else $error("disabled switcher does not pull the rail low");

   a_range_linear_low: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_enabled_range(2'h1) |=>
      (regulated_rail_voltage_o == 12'(12'd1300 + 12'd100 * $past(vout_ctrl_reg[4:1]))))
      else $error("range 01 target voltage is wrong");

   a_range_linear_high: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_enabled_range(2'h3) |=>
      (regulated_rail_voltage_o == 12'(12'd1800 + 12'd100 * $past(vout_ctrl_reg[4:1]))))
      else $error("range 11 target voltage is wrong");

   a_range_table_ends: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_enabled_range(2'h0) |=>
      (($past(vout_ctrl_reg[4:1]) != 4'h0 || regulated_rail_voltage_o == 12'd1100) &&
       ($past(vout_ctrl_reg[4:1]) != 4'hF || regulated_rail_voltage_o == 12'd2333)))
      else $error("range 00 lookup gives a wrong end value");

   a_range_table_high: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_enabled_range(2'h2) |=>
      (regulated_rail_voltage_o >= 12'd1500 && regulated_rail_voltage_o <= 12'd2750 &&
       ($past(vout_ctrl_reg[4:1]) != 4'hF || regulated_rail_voltage_o == 12'd2750)))
      else $error("range 10 lookup is out of its span");

   a_code_bit_weight: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_enabled_range(2'h1) ##1 s_enabled_range(2'h1) ##0
      ($past(vout_ctrl_reg[4:1]) == 4'h8 && vout_ctrl_reg[4:1] == 4'h0)
      |=> ($past(regulated_rail_voltage_o) - regulated_rail_voltage_o == 12'd800))
      else $error("code bit 4 does not weigh 800 mV");

   // Rail and switching checks look one edge after the register, as both are registered.
   a_reset_rail_target: assert property (
      @(posedge ref_clk_i) (!$past(rst_n_i) && rst_n_i) |->
      (regulated_rail_voltage_o == 12'd1800 && switching_node_output_o &&
       reg_rd_data_o == 8'h00))
      else $error("rail target or read data wrong after reset release");

   a_unmapped_read_zero: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_read_other |=> (reg_rd_data_o == 8'h00))
      else $error("read of an unmapped address did not return zero");

   a_read_data_holds: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !reg_rd_en_i |=> $stable(reg_rd_data_o))
      else $error("read data changed without a read request");

   a_read_before_write: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (s_read_hit ##0 s_write_hit) |=>
      (reg_rd_data_o == $past(vout_ctrl_reg) &&
       vout_ctrl_reg[7:1] == $past(reg_wr_data_i[7:1])))
      else $error("read in the cycle of a write did not return the old value");

   a_enable_restores: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      vout_ctrl_reg[7] [*2] |->
      (switching_node_output_o && regulated_rail_voltage_o >= 12'd1100))
      else $error("enabled switcher does not drive the rail");

   a_table_low_mid: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_enabled_code(2'h0, 4'h5) |=> (regulated_rail_voltage_o == 12'd1500))
      else $error("range 00 code 0101 does not give 1.5 V");

   a_table_high_base: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_enabled_code(2'h2, 4'h0) |=> (regulated_rail_voltage_o == 12'd1500))
      else $error("range 10 code 0000 does not give 1.5 V");

endmodule

// >>> verif/testbench.sv
// Self-checking bench for the output voltage control register and its decoder.
`timescale 1ns/1ps
module testbench;
   import vout_ctrl_pkg::*;

   logic              ref_clk_i;
   logic              rst_n_i;
   logic [7:0]        reg_addr_i;
   logic              reg_wr_en_i;
   logic [7:0]        reg_wr_data_i;
   logic              reg_rd_en_i;
   logic [7:0]        reg_rd_data_o;
   logic              switcher_output_enable_o;
   logic [1:0]        output_range_select_o;
   logic [3:0]        output_voltage_code_o;
   logic              switching_node_output_o;
   logic [11:0]       regulated_rail_voltage_o;
   int                n_fail;
   int                checked;

   vout_ctrl_reg dut_u (
      .ref_clk_i                (ref_clk_i),
      .rst_n_i                  (rst_n_i),
      .reg_addr_i               (reg_addr_i),
      .reg_wr_en_i              (reg_wr_en_i),
      .reg_wr_data_i            (reg_wr_data_i),
      .reg_rd_en_i              (reg_rd_en_i),
      .reg_rd_data_o            (reg_rd_data_o),
      .switcher_output_enable_o (switcher_output_enable_o),
      .output_range_select_o    (output_range_select_o),
      .output_voltage_code_o    (output_voltage_code_o),
      .switching_node_output_o  (switching_node_output_o),
      .regulated_rail_voltage_o (regulated_rail_voltage_o)
   );

   // ----------------------------------------------------------------------
   // Clock, compare and bus helpers
   // ----------------------------------------------------------------------
   initial begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Write lands one edge after the strobe, decoded rail one edge later still.
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(posedge ref_clk_i);
      reg_wr_en_i   <= 1'b1;
      reg_addr_i    <= addr;
      reg_wr_data_i <= data;
      @(posedge ref_clk_i);
      reg_wr_en_i <= 1'b0;
      @(posedge ref_clk_i);
      #1;
   endtask

   task automatic rd(input logic [7:0] addr, output logic [7:0] data);
      @(posedge ref_clk_i);
      reg_rd_en_i <= 1'b1;
      reg_addr_i  <= addr;
      @(posedge ref_clk_i);
      reg_rd_en_i <= 1'b0;
      #1;
      data = reg_rd_data_o;
   endtask

   function automatic logic [11:0] exp_mv(input logic [1:0] r, input logic [3:0] c);
      int n;
      n = (r == 2'h2) ? int'(c) + 5 : int'(c);
      if (r == 2'h1) return 12'(1300 + 100 * int'(c));
      if (r == 2'h3) return 12'(1800 + 100 * int'(c));
      if (n < 2) return (n == 0) ? 12'd1100 : 12'd1200;
      return 12'(1250 + ((n - 2) * 500 + 3) / 6);
   endfunction

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task automatic t_reset();
      logic [7:0] d;
      chk("enable", 16'(switcher_output_enable_o), 16'h0001);
      chk("range", 16'(output_range_select_o), 16'h0001);
      chk("code", 16'(output_voltage_code_o), 16'h0005);
      chk("rail", 16'(regulated_rail_voltage_o), 16'd1800);
      chk("switch", 16'(switching_node_output_o), 16'h0001);
      chk("rd_reset", 16'(reg_rd_data_o), 16'h0000);
      rd(8'h06, d);
      chk("reset_read", 16'(d), 16'h00AA);
   endtask

   task automatic t_decode();
      logic [7:0] d;
      for (int r = 0; r < 4; r++) begin
         for (int c = 0; c < 16; c++) begin
            wr(8'h06, {1'b1, 2'(r), 4'(c), 1'b1});
            chk("range", 16'(output_range_select_o), 16'(r));
            chk("code", 16'(output_voltage_code_o), 16'(c));
            chk("rail", 16'(regulated_rail_voltage_o), 16'(exp_mv(2'(r), 4'(c))));
            rd(8'h06, d);
            chk("readback", 16'(d), 16'({1'b1, 2'(r), 4'(c), 1'b0}));
         end
      end
   endtask

   task automatic t_disable();
      wr(8'h06, 8'h7E);
      chk("enable_off", 16'(switcher_output_enable_o), 16'h0000);
      chk("switch_off", 16'(switching_node_output_o), 16'h0000);
      chk("rail_off", 16'(regulated_rail_voltage_o), 16'h0000);
      wr(8'h06, 8'hE0);
      chk("switch_on", 16'(switching_node_output_o), 16'h0001);
      chk("rail_on", 16'(regulated_rail_voltage_o), 16'd1800);
   endtask

   task automatic t_unmapped();
      logic [7:0] d;
      wr(8'h07, 8'h01);
      rd(8'h06, d);
      chk("mapped_kept", 16'(d), 16'h00E0);
      rd(8'h07, d);
      chk("unmapped_read", 16'(d), 16'h0000);
   endtask

   task automatic t_order();
      logic [7:0] d;
      @(posedge ref_clk_i);
      reg_wr_en_i   <= 1'b1;
      reg_rd_en_i   <= 1'b1;
      reg_addr_i    <= 8'h06;
      reg_wr_data_i <= 8'h34;
      @(posedge ref_clk_i);
      reg_wr_en_i <= 1'b0;
      reg_rd_en_i <= 1'b0;
      #1;
      chk("read_old", 16'(reg_rd_data_o), 16'h00E0);
      rd(8'h06, d);
      chk("read_new", 16'(d), 16'h0034);
      wr(8'h06, 8'hB0);
      chk("weight_800", 16'(regulated_rail_voltage_o), 16'd2100);
      wr(8'h06, 8'hA0);
      chk("weight_base", 16'(regulated_rail_voltage_o), 16'd1300);
   endtask

   task automatic t_mid_reset();
      logic [7:0] d;
      wr(8'h06, 8'h7E);
      @(posedge ref_clk_i);
      rst_n_i <= 1'b0;
      @(posedge ref_clk_i);
      #1;
      chk("rd_in_reset", 16'(reg_rd_data_o), 16'h0000);
      chk("enable_in_reset", 16'(switcher_output_enable_o), 16'h0001);
      repeat (3) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      @(posedge ref_clk_i);
      #1;
      chk("rail_after_reset", 16'(regulated_rail_voltage_o), 16'd1800);
      chk("switch_after_reset", 16'(switching_node_output_o), 16'h0001);
      rd(8'h06, d);
      chk("read_after_reset", 16'(d), 16'h00AA);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      #2000000;
      n_fail++;
      report_and_stop();
   end

   initial begin
      n_fail        = 0;
      checked       = 0;
      rst_n_i       = 1'b0;
      reg_addr_i    = 8'h00;
      reg_wr_en_i   = 1'b0;
      reg_wr_data_i = 8'h00;
      reg_rd_en_i   = 1'b0;
      repeat (16) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      @(posedge ref_clk_i);
      #1;
      t_reset();
      t_decode();
      t_disable();
      t_unmapped();
      t_order();
      t_mid_reset();
      report_and_stop();
   end
endmodule
